// ===== core/sbr_pkg.sv
package sbr_pkg;
    // ======================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] BANK_ENABLE_ADDR = 8'h00;
    localparam logic [7:0] BANK_DISABLE_ADDR = 8'h04;
    localparam logic [7:0] RETAIN_ADDR = 8'h08;
    localparam logic [7:0] NMI_ENABLE_ADDR = 8'h0c;
    localparam logic [7:0] NMI_FLAG_ADDR = 8'h10;
    localparam logic [7:0] RESET_CFG_ADDR = 8'h14;
    localparam logic [7:0] REBOOT_ADDR = 8'h18;
    localparam logic [7:0] FLASH_SIZE_ADDR = 8'h1c;
    localparam logic [7:0] SRAM_SIZE_ADDR = 8'h20;
    localparam logic [7:0] INFO_BASE_ADDR = 8'h40;
    localparam int INFO_ADDR_BITS = 4;
    // ======================================================
    // field layout
    localparam int NUM_BANKS = 8;
    localparam int NUM_NMI = 4;
    localparam int NMI_PIN_BIT = 0;
    localparam int PWV_TYPE_BIT = 0;
    localparam int TMO_TYPE_BIT = 1;
    localparam int REBOOT_BIT = 0;
    localparam logic BASE_BANK_ON = 1'b1;
    // ======================================================
    // reset values
    localparam logic [7:0] BANK_MASK_RESET = 8'hff;
    localparam logic [7:0] RETAIN_RESET = 8'h01;
    localparam logic [3:0] NMI_ENABLE_RESET = 4'h1;
    localparam logic [1:0] RESET_CFG_RESET = 2'h3;
    localparam logic FULL_RESET_TYPE = 1'b1;
    // ======================================================
    // tagged info table layout: {tag, length in words, 16'h0}
    localparam logic [7:0] TAG_CAL = 8'h08;
    localparam logic [7:0] TAG_DEVINFO = 8'h0b;
    localparam logic [7:0] TAG_END = 8'hff;
    localparam logic [7:0] CAL_LEN = 8'h03;
    localparam logic [7:0] DEVINFO_LEN = 8'h01;
    // bus handshake states
    typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_ACK} sbr_bus_t;
endpackage : sbr_pkg

// ===== core/sbr_info_if.sv
`timescale 1ns/10ps
interface sbr_info_if #(
    parameter int ADDR_BITS = 4
);
    logic [ADDR_BITS-1:0] addr;
    logic [31:0] data;
    modport ctrl (output addr, input data);
    modport store (input addr, output data);
endinterface : sbr_info_if

// ===== core/sbr_info_rom.sv
`timescale 1ns/10ps
module sbr_info_rom #(
    parameter int DEPTH = 16,
    parameter logic [15:0] CAL_30_R0 = 16'h1000,
    parameter logic [15:0] CAL_85_R0 = 16'h1200,
    parameter logic [15:0] CAL_30_R1 = 16'h1400,
    parameter logic [15:0] CAL_85_R1 = 16'h1600,
    parameter logic [15:0] CAL_30_R2 = 16'h1800,
    parameter logic [15:0] CAL_85_R2 = 16'h1a00,
    parameter logic [31:0] DEVICE_ID = 32'h0000_a5a5 // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // lookup port
    sbr_info_if.store info
);
    // ======================================================
    // table contents: each segment header then its data words
    function automatic logic [31:0] entry(input int idx);
        unique case (idx)
            0: entry = {sbr_pkg::TAG_CAL, sbr_pkg::CAL_LEN, 16'h0000};
            1: entry = {CAL_85_R0, CAL_30_R0};
            2: entry = {CAL_85_R1, CAL_30_R1};
            3: entry = {CAL_85_R2, CAL_30_R2};
            4: entry = {sbr_pkg::TAG_DEVINFO, sbr_pkg::DEVINFO_LEN, 16'h0000};
            5: entry = DEVICE_ID;
            6: entry = {sbr_pkg::TAG_END, 24'h000000};
            default: entry = 32'h0000_0000;
        endcase
    endfunction : entry

    logic [31:0] next_q;
    logic [31:0] q;

    // read data leave a register, so lookups take one cycle
    always_comb begin
        next_q = 32'h0000_0000;
        for (int i = 0; i < DEPTH; i++) begin
            if (info.addr == i[$bits(info.addr)-1:0]) begin
                next_q = entry(i);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= 32'h0000_0000;
        end else begin
            q <= next_q;
        end
    end

    assign info.data = q;
endmodule : sbr_info_rom

// ===== core/sbr_sys_ctrl.sv
`timescale 1ns/10ps
module sbr_sys_ctrl #(
    parameter logic [31:0] FLASH_BYTES = 32'h0004_0000,
    parameter logic [31:0] SRAM_BYTES = 32'h0001_0000
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // system events
    input wire logic softReset,
    input wire logic deepLowPowerMode,
    input wire logic wdtTimeout,
    input wire logic wdtPasswordViolation,
    input wire logic [3:0] nmiFault,
    // power and reset controls
    output logic [7:0] bankPower,
    output logic [7:0] bankRetain,
    output logic nmiRequest,
    output logic hardResetReq,
    output logic softResetReq
);
    // ======================================================
    // helpers
    // one-hot tier request decode, {valid, index}
    function automatic logic [3:0] tierOf(input logic [7:0] w);
        tierOf = 4'h0;
        for (int i = 1; i < sbr_pkg::NUM_BANKS; i++) begin
            if (w == (8'h01 << i)) begin
                tierOf = {1'b1, i[2:0]};
            end
        end
    endfunction : tierOf

    // banks 0..idx set
    function automatic logic [7:0] lowMask(input logic [2:0] idx);
        lowMask = 8'hff >> (3'd7 - idx);
    endfunction : lowMask

    // ======================================================
    // bus handshake
    sbr_pkg::sbr_bus_t busState;
    sbr_pkg::sbr_bus_t next_busState;
    logic next_waitrequest;
    logic [31:0] next_readdata;
    logic [31:0] readMux;
    logic wrCommit;
    logic wrLane0;

    sbr_info_if #(.ADDR_BITS(sbr_pkg::INFO_ADDR_BITS)) infoBus ();

    sbr_info_rom #(.DEPTH(16)) infoRom (
        .clk(clk),
        .reset_n(reset_n),
        .info(infoBus)
    );

    // word index inside the info window; master holds the address
    assign infoBus.addr = avs_address[5:2];

    // state and config registers declared ahead of the read mux
    logic [7:0] bankMask;
    logic [7:0] retainMask;
    logic [3:0] nmiEnable;
    logic [3:0] nmiFlag;
    logic [1:0] resetCfg;

    // read mux; unmapped words read zero
    always_comb begin
        readMux = 32'h0000_0000;
        if (avs_address[7:6] == sbr_pkg::INFO_BASE_ADDR[7:6]) begin
            readMux = infoBus.data;
        end else begin
            unique case ({avs_address[7:2], 2'b00})
                sbr_pkg::BANK_ENABLE_ADDR: readMux = {24'h0, bankMask};
                sbr_pkg::BANK_DISABLE_ADDR: readMux = {24'h0, bankMask};
                sbr_pkg::RETAIN_ADDR: readMux = {24'h0, retainMask};
                sbr_pkg::NMI_ENABLE_ADDR: readMux = {28'h0, nmiEnable};
                sbr_pkg::NMI_FLAG_ADDR: readMux = {28'h0, nmiFlag};
                sbr_pkg::RESET_CFG_ADDR: readMux = {30'h0, resetCfg};
                sbr_pkg::FLASH_SIZE_ADDR: readMux = FLASH_BYTES;
                sbr_pkg::SRAM_SIZE_ADDR: readMux = SRAM_BYTES;
                default: readMux = 32'h0000_0000;
            endcase
        end
    end

    // two wait cycles give the table register time to settle
    always_comb begin
        next_busState = busState;
        next_readdata = avs_readdata;
        unique case (busState)
            sbr_pkg::BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_busState = sbr_pkg::BUS_WAIT;
                end
            end
            sbr_pkg::BUS_WAIT: begin
                next_busState = sbr_pkg::BUS_ACK;
                if (avs_read) begin
                    next_readdata = readMux;
                end
            end
            sbr_pkg::BUS_ACK: begin
                next_busState = sbr_pkg::BUS_IDLE;
            end
        endcase
        next_waitrequest = (next_busState != sbr_pkg::BUS_ACK);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busState <= sbr_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            busState <= next_busState;
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
        end
    end

    // a write lands at the edge that samples waitrequest low
    assign wrCommit = avs_write && (busState == sbr_pkg::BUS_ACK);
    assign wrLane0 = wrCommit && avs_byteenable[0];

    // ======================================================
    // bank power and retention
    logic [7:0] next_bankMask;
    logic [7:0] next_retainMask;
    logic [7:0] next_bankPower;
    logic [7:0] next_bankRetain;
    logic [3:0] tierReq;
    logic [7:0] wrByte;

    assign wrByte = avs_writedata[7:0];
    assign tierReq = tierOf(wrByte);

    // whole mask replaced in one edge, never half-updated
    always_comb begin
        next_bankMask = bankMask;
        next_retainMask = retainMask;
        if (wrLane0 && tierReq[3]) begin
            if (avs_address == sbr_pkg::BANK_ENABLE_ADDR) begin
                next_bankMask = bankMask | lowMask(tierReq[2:0]);
            end
            if (avs_address == sbr_pkg::BANK_DISABLE_ADDR) begin
                next_bankMask = bankMask
                    & (lowMask(tierReq[2:0]) >> 1);
            end
        end
        if (wrLane0 && avs_address == sbr_pkg::RETAIN_ADDR) begin
            next_retainMask = wrByte;
        end
        next_bankMask[0] = sbr_pkg::BASE_BANK_ON;
        next_retainMask[0] = sbr_pkg::BASE_BANK_ON;
        next_bankPower = next_bankMask;
        // retention of banks 1 to 7 only counts while the deep mode is held; bank 0 is always retained
        next_bankRetain = deepLowPowerMode ? next_retainMask : 8'h00;
        next_bankRetain[0] = sbr_pkg::BASE_BANK_ON;
    end

    // soft reset is not looked at here: settings survive it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bankMask <= sbr_pkg::BANK_MASK_RESET;
            retainMask <= sbr_pkg::RETAIN_RESET;
            bankPower <= sbr_pkg::BANK_MASK_RESET;
            bankRetain <= sbr_pkg::RETAIN_RESET;
        end else begin
            bankMask <= next_bankMask;
            retainMask <= next_retainMask;
            bankPower <= next_bankPower;
            bankRetain <= next_bankRetain;
        end
    end

    // ======================================================
    // nmi sources; all four synchronised, the pin is asynchronous
    logic [3:0] faultMeta;
    logic [3:0] faultSync;
    logic [3:0] next_nmiEnable;
    logic [3:0] next_nmiFlag;
    logic next_nmiRequest;
    logic [3:0] flagClear;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            faultMeta <= 4'h0;
            faultSync <= 4'h0;
        end else begin
            faultMeta <= nmiFault;
            faultSync <= faultMeta;
        end
    end

    assign flagClear = (wrLane0 && avs_address == sbr_pkg::NMI_FLAG_ADDR)
        ? avs_writedata[3:0] : 4'h0;

    // write one or soft reset clears a flag; a fault in that cycle wins
    always_comb begin
        next_nmiEnable = nmiEnable;
        if (wrLane0 && avs_address == sbr_pkg::NMI_ENABLE_ADDR) begin
            next_nmiEnable = avs_writedata[3:0];
        end
        next_nmiFlag = nmiFlag & ~flagClear;
        if (softReset) begin
            next_nmiFlag = 4'h0;
        end
        // set applied last so a coinciding fault is never lost
        next_nmiFlag = next_nmiFlag | (faultSync & nmiEnable);
        next_nmiRequest = |next_nmiFlag;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nmiEnable <= sbr_pkg::NMI_ENABLE_RESET;
            nmiFlag <= 4'h0;
            nmiRequest <= 1'b0;
        end else begin
            nmiEnable <= next_nmiEnable;
            nmiFlag <= next_nmiFlag;
            nmiRequest <= next_nmiRequest;
        end
    end

    // ======================================================
    // reset type selection and reboot
    logic [1:0] next_resetCfg;
    logic next_hardResetReq;
    logic next_softResetReq;
    logic rebootHit;
    logic wantHard;
    logic wantSoft;

    assign rebootHit = wrLane0 && avs_address == sbr_pkg::REBOOT_ADDR
        && avs_writedata[sbr_pkg::REBOOT_BIT];

    // one pulse per event; hard takes priority over soft
    always_comb begin
        next_resetCfg = resetCfg;
        if (wrLane0 && avs_address == sbr_pkg::RESET_CFG_ADDR) begin
            next_resetCfg = avs_writedata[1:0];
        end
        wantHard = rebootHit
            || (wdtPasswordViolation
                && resetCfg[sbr_pkg::PWV_TYPE_BIT]
                    == sbr_pkg::FULL_RESET_TYPE)
            || (wdtTimeout
                && resetCfg[sbr_pkg::TMO_TYPE_BIT]
                    == sbr_pkg::FULL_RESET_TYPE);
        wantSoft = (wdtPasswordViolation
                && resetCfg[sbr_pkg::PWV_TYPE_BIT]
                    != sbr_pkg::FULL_RESET_TYPE)
            || (wdtTimeout
                && resetCfg[sbr_pkg::TMO_TYPE_BIT]
                    != sbr_pkg::FULL_RESET_TYPE);
        next_hardResetReq = wantHard;
        next_softResetReq = wantSoft && !wantHard;
    end

    // reset type config is set back to 3 only by the hard reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resetCfg <= sbr_pkg::RESET_CFG_RESET;
            hardResetReq <= 1'b0;
            softResetReq <= 1'b0;
        end else begin
            resetCfg <= next_resetCfg;
            hardResetReq <= next_hardResetReq;
            softResetReq <= next_softResetReq;
        end
    end
endmodule : sbr_sys_ctrl

// ===== tb/sbr_sys_ctrl_props.sv
`timescale 1ns/10ps
// ==========================================
// port checker for the system control block
module sbr_sys_ctrl_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // events
    input wire logic wdtTimeout,
    input wire logic wdtPasswordViolation,
    input wire logic deepLowPowerMode,
    input wire logic [3:0] nmiFault,
    // controls
    input wire logic [7:0] bankPower,
    input wire logic [7:0] bankRetain,
    input wire logic nmiRequest,
    input wire logic hardResetReq,
    input wire logic softResetReq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // acknowledge stands one cycle only
    sequence ack_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence reboot_s;
        avs_write && !avs_waitrequest && avs_address == sbr_pkg::REBOOT_ADDR;
    endsequence
    bus_ack_a: assert property ($rose(avs_read | avs_write) |-> ##[1:3] ack_s)
        else $error("bus acknowledge missing");
    base_bank_a: assert property (bankPower[0] && bankRetain[0])
        else $error("base bank dropped");
    tier_contig_a: assert property (
        ((bankPower + 8'h01) & bankPower) == 8'h00)
        else $error("bank power mask not contiguous");
    retain_sleep_a: assert property (
        bankRetain != 8'h01 |-> $past(deepLowPowerMode))
        else $error("retention outside deep low power");
    tmo_type_a: assert property (
        wdtTimeout |=> hardResetReq ^ softResetReq)
        else $error("timeout gave no single reset");
    pwv_type_a: assert property (
        wdtPasswordViolation |=> hardResetReq ^ softResetReq)
        else $error("password violation gave no single reset");
    soft_cause_a: assert property (
        softResetReq |-> $past(wdtTimeout | wdtPasswordViolation))
        else $error("soft reset without watchdog event");
    hard_cause_a: assert property (
        hardResetReq |-> $past(wdtTimeout | wdtPasswordViolation)
        or $past(avs_write && !avs_waitrequest
        && avs_address == sbr_pkg::REBOOT_ADDR))
        else $error("hard reset without cause");
    nmi_cause_a: assert property (
        $rose(nmiRequest) |-> $past(|nmiFault, 2))
        else $error("nmi request without fault");
    reboot_c: cover property (reboot_s);
endmodule : sbr_sys_ctrl_props

bind sbr_sys_ctrl sbr_sys_ctrl_props chk_u (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .wdtTimeout(wdtTimeout),
    .wdtPasswordViolation(wdtPasswordViolation),
    .deepLowPowerMode(deepLowPowerMode), .nmiFault(nmiFault),
    .bankPower(bankPower), .bankRetain(bankRetain),
    .nmiRequest(nmiRequest), .hardResetReq(hardResetReq),
    .softResetReq(softResetReq)
);

// ===== tb/sbr_sys_ctrl_tb.sv
`timescale 1ns/10ps
module sbr_sys_ctrl_tb;
    // sizes differ from defaults so the parameters are really used
    localparam logic [31:0] FLASH_B = 32'h0002_0000;
    localparam logic [31:0] SRAM_B = 32'h0000_8000;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic softReset = 1'b0;
    logic deepLowPowerMode = 1'b0;
    logic wdtTimeout = 1'b0;
    logic wdtPasswordViolation = 1'b0;
    logic [3:0] nmiFault = 4'h0;
    logic [7:0] bankPower;
    logic [7:0] bankRetain;
    logic nmiRequest;
    logic hardResetReq;
    logic softResetReq;
    int errors = 0;
    int num_checks = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    sbr_sys_ctrl #(.FLASH_BYTES(FLASH_B), .SRAM_BYTES(SRAM_B)) dut_u (
        .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .softReset(softReset), .deepLowPowerMode(deepLowPowerMode),
        .wdtTimeout(wdtTimeout), .wdtPasswordViolation(wdtPasswordViolation),
        .nmiFault(nmiFault), .bankPower(bankPower), .bankRetain(bankRetain),
        .nmiRequest(nmiRequest), .hardResetReq(hardResetReq),
        .softResetReq(softResetReq)
    );

    // ======================================
    // tasks
    task automatic print_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // request held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // no local limit: only the watchdog ends a stuck wait
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rdc

    // one-cycle event pulse: {softReset, timeout, password}
    task automatic evt(input logic [2:0] m);
        @(posedge clk);
        {softReset, wdtTimeout, wdtPasswordViolation} <= m;
        @(posedge clk);
        {softReset, wdtTimeout, wdtPasswordViolation} <= 3'h0;
    endtask : evt

    // ======================================
    // watchdog, far beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        print_verdict();
    end

    // ======================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        check(32'(bankPower), 32'hff);
        check(32'(bankRetain), 32'h01);
        rdc(sbr_pkg::RETAIN_ADDR, 32'h01);
        rdc(sbr_pkg::NMI_ENABLE_ADDR, 32'h1);
        rdc(sbr_pkg::RESET_CFG_ADDR, 32'h3);
        rdc(sbr_pkg::FLASH_SIZE_ADDR, FLASH_B);
        rdc(sbr_pkg::SRAM_SIZE_ADDR, SRAM_B);
        wr(8'h30, 32'hffff_ffff);
        rdc(8'h30, 32'h0);
        // every tier up then down, from a single-bank start
        for (int k = 1; k < 8; k++) begin
            wr(sbr_pkg::BANK_DISABLE_ADDR, 32'h2);
            wr(sbr_pkg::BANK_ENABLE_ADDR, 32'h1 << k);
            rdc(sbr_pkg::BANK_ENABLE_ADDR, (32'h2 << k) - 1);
            check(32'(bankPower), (32'h2 << k) - 1);
            wr(sbr_pkg::BANK_DISABLE_ADDR, 32'h1 << k);
            // power output is launched at the commit edge; look one later
            @(posedge clk);
            check(32'(bankPower), (32'h1 << k) - 1);
        end
        // two tiers at once and bank zero are both refused
        wr(sbr_pkg::BANK_ENABLE_ADDR, 32'hc0);
        wr(sbr_pkg::BANK_DISABLE_ADDR, 32'h1);
        rdc(sbr_pkg::BANK_DISABLE_ADDR, 32'h7f);
        wr(sbr_pkg::RETAIN_ADDR, 32'ha6);
        rdc(sbr_pkg::RETAIN_ADDR, 32'ha7);
        // a write without lane 0 must leave the retention mask alone
        avs_byteenable <= 4'he;
        wr(sbr_pkg::RETAIN_ADDR, 32'h00);
        avs_byteenable <= 4'hf;
        rdc(sbr_pkg::RETAIN_ADDR, 32'ha7);
        check(32'(bankRetain), 32'h01);
        deepLowPowerMode <= 1'b1;
        repeat (3) @(posedge clk);
        check(32'(bankRetain), 32'ha7);
        evt(3'h4);
        deepLowPowerMode <= 1'b0;
        rdc(sbr_pkg::RETAIN_ADDR, 32'ha7);
        // each source alone; the other faults must be ignored
        for (int i = 0; i < 4; i++) begin
            wr(sbr_pkg::NMI_ENABLE_ADDR, 32'h1 << i);
            rdc(sbr_pkg::NMI_ENABLE_ADDR, 32'h1 << i);
            nmiFault <= ~(4'h1 << i);
            repeat (6) @(posedge clk);
            check(32'(nmiRequest), 32'h0);
            nmiFault <= 4'hf;
            repeat (6) @(posedge clk);
            check(32'(nmiRequest), 32'h1);
            nmiFault <= 4'h0;
            rdc(sbr_pkg::NMI_FLAG_ADDR, 32'h1 << i);
            wr(sbr_pkg::NMI_FLAG_ADDR, 32'hf);
            rdc(sbr_pkg::NMI_FLAG_ADDR, 32'h0);
        end
        // all four reset-type settings, both watchdog events
        for (int c = 0; c < 4; c++) begin
            wr(sbr_pkg::RESET_CFG_ADDR, 32'(c));
            evt(3'h2);
            @(posedge clk);
            check(32'({hardResetReq, softResetReq}), c[1] ? 32'h2 : 32'h1);
            evt(3'h1);
            @(posedge clk);
            check(32'({hardResetReq, softResetReq}), c[0] ? 32'h2 : 32'h1);
        end
        wr(sbr_pkg::RESET_CFG_ADDR, 32'h2);
        evt(3'h4);
        rdc(sbr_pkg::RESET_CFG_ADDR, 32'h2);
        rdc(sbr_pkg::INFO_BASE_ADDR, {sbr_pkg::TAG_CAL, sbr_pkg::CAL_LEN, 16'h0});
        rdc(sbr_pkg::INFO_BASE_ADDR + 8'h04, 32'h1200_1000);
        rdc(sbr_pkg::INFO_BASE_ADDR + 8'h08, 32'h1600_1400);
        rdc(sbr_pkg::INFO_BASE_ADDR + 8'h0c, 32'h1a00_1800);
        rdc(sbr_pkg::INFO_BASE_ADDR + 8'h10, {sbr_pkg::TAG_DEVINFO, sbr_pkg::DEVINFO_LEN, 16'h0});
        rdc(sbr_pkg::INFO_BASE_ADDR + 8'h18, {sbr_pkg::TAG_END, 24'h0});
        wr(sbr_pkg::REBOOT_ADDR, 32'h1);
        @(posedge clk);
        check(32'(hardResetReq), 32'h1);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rdc(sbr_pkg::RESET_CFG_ADDR, 32'h3);
        rdc(sbr_pkg::RETAIN_ADDR, 32'h01);
        print_verdict();
    end
endmodule : sbr_sys_ctrl_tb
